// ### hw/lbd_consts.svh
// Constants of the local bus address decoder
//
// Operation
// [R1] Only access type codes 0, 1 and 2 use the normal memory map.
// [R2] Onboard resources answer normal and interrupt acknowledge cycles, nothing else.
// [R3] After reset boot memory decodes at FF800000-FF9FFFFF and 0-003FFFFF.
// [R4] Software switches off the low boot alias before enabling DRAM.
// [R5] DRAM control bit 24 at FFF42048 enables onboard DRAM decoding.
// [R6] Boot control bit 20 at FFF42040 switches off the low boot alias.
// [R7] FFA00000-FFBFFFFF goes to flash with jumper fitted, else PROM.
// [R8] Boot memory uses an 8-bit private bus; upper address bits ignored.
// [R9] FFC00000-FFDFFFFF and FFE80000-FFEFFFFF stay undecoded and time out; the code selects DRAM or the programmable window there when one matches.
// [R10] Reserved space never acknowledges; enabled timer ends it with transfer error.
// [R11] Local CSR block writes must be 32 bits; narrower writes end with error.
// [R12] Global CSR takes 8/16/32-bit writes; both CSR blocks take any read.
// [R13] Masters should read the interrupt vector with byte reads.
// [R14] Masters reach the serial controller with single byte transfers only.
// [R15] Network port commands are two 16-bit writes, upper halfword first.
// [R16] Inbound remote window has programmable start, end and accepted modifiers.
// [R17] Global CSR sits in remote short I/O space at programmable base.
// [R18] Timeout selectable 8, 64, 256 us or infinite; expiry gives transfer error.
// [R19] At most one target select; fixed regions beat programmable windows.
`ifndef LBD_CONSTS_SVH
`define LBD_CONSTS_SVH
`define CLK_MHZ 200
`define TO_SHORT_US 8
`define TO_MID_US 64
`define TO_LONG_US 256
`define TO_SEL_SHORT 2'h0
`define TO_SEL_MID 2'h1
`define TO_SEL_LONG 2'h2
`define TT_IACK 2'h3
`define BOOT_LO 32'hFF800000
`define BOOT_HI 32'hFF9FFFFF
`define ALT_LO 32'hFFA00000
`define ALT_HI 32'hFFBFFFFF
`define ALIAS_HI 32'h003FFFFF
`define SRAM_LO 32'hFFE00000
`define SRAM_HI 32'hFFE7FFFF
`define IO_LO 32'hFFF00000
`define LOCAL_CTRL_STATUS_BLOCK_LO 32'hFFF40000
`define LOCAL_CTRL_STATUS_BLOCK_HI 32'hFFF400FF
`define GLOBAL_CTRL_STATUS_BLOCK_LO 32'hFFF40100
`define GLOBAL_CTRL_STATUS_BLOCK_HI 32'hFFF401FF
`define CTRL_LO 32'hFFF42000
`define CTRL_HI 32'hFFF42FFF
`define BOOTCTL_ADR 32'hFFF42040
`define DRAMCTL_ADR 32'hFFF42048
`define SCC_LO 32'hFFF45000
`define SCC_HI 32'hFFF45FFF
`define LAN_LO 32'hFFF46000
`define LAN_HI 32'hFFF46FFF
`define SCSI_LO 32'hFFF47000
`define SCSI_HI 32'hFFF47FFF
`define IP_LO 32'hFFF58000
`define IP_HI 32'hFFF587FF
`define IPREG_LO 32'hFFFBC000
`define IPREG_HI 32'hFFFBC01F
`define RTC_LO 32'hFFFC0000
`define RTC_HI 32'hFFFCFFFF
`define A16_LO 32'hFFFF0000
`define ALIAS_OFF_BIT 20
`define DRAM_EN_BIT 24
`define BOOTCTL_RST 32'h00000000
`define DRAMCTL_RST 32'h00000000
`define ROM_AW_DEF 19
`endif

// ### hw/lbd_pkg.sv
// Types of the local bus address decoder
package lbd_pkg;
   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_HALF = 2'h1,
      SZ_WORD = 2'h2,
      SZ_LINE = 2'h3
   } size_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] access_type_code;
      size_t size;
      logic write;
      logic [31:0] wdata;
   } lb_req_t;
   typedef struct packed {
      logic cs;
      logic flash;
      logic rd;
      logic wr;
      logic [23:0] addr;
      logic [7:0] wdata;
   } rom_bus_t;
   localparam int NTGT = 13;
   typedef enum logic [3:0] {
      T_DRAM = 4'h0, T_SRAM = 4'h1, T_LOCAL_CTRL_STATUS_BLOCK = 4'h2, T_GLOBAL_CTRL_STATUS_BLOCK = 4'h3,
      T_CTRL = 4'h4, T_SCC = 4'h5, T_LAN = 4'h6, T_SCSI = 4'h7,
      T_IP = 4'h8, T_RTC = 4'h9, T_A16 = 4'hA, T_PROG = 4'hB,
      T_IACK = 4'hC, T_REGS = 4'hD, T_BOOT = 4'hE, T_NONE = 4'hF
   } tgt_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_TGT = 3'b010,
      ST_ROM = 3'b100
   } state_t;
endpackage

// ### hw/lbus_timeout.sv
// Local bus timeout counter
`timescale 1ns/1ps
`default_nettype none
`include "lbd_consts.svh"
module lbus_timeout #(
   parameter int SHORT_CYC = 1600,
   parameter int MID_CYC = 12800,
   parameter int LONG_CYC = 51200
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic run,
   input wire logic [1:0] to_sel,
   output logic expired
);
   localparam int CW = $clog2(LONG_CYC + 1);
   logic [CW-1:0] cnt, next_cnt, lim;
   logic inf, next_expired;

   always_comb begin
      inf = 1'b0;
      case (to_sel)
         `TO_SEL_SHORT: lim = CW'(SHORT_CYC);
         `TO_SEL_MID: lim = CW'(MID_CYC);
         `TO_SEL_LONG: lim = CW'(LONG_CYC);
         default: begin
            lim = '1;
            inf = 1'b1;
         end
      endcase
      // Counter holds at the limit so expiry fires once per access
      next_cnt = !run ? '0 : (cnt < lim ? cnt + CW'(1) : cnt);
      next_expired = run && !inf && cnt == lim - CW'(1); // [R18]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= '0;
         expired <= 1'b0;
      end else begin
         cnt <= next_cnt;
         expired <= next_expired;
      end
   end

   no_inf_expiry_a: assert property (@(posedge clk) disable iff (!arst_n)
      to_sel == 2'h3 && $stable(to_sel) |=> !expired) else $error("expiry with infinite timeout"); // [R18]
endmodule
`default_nettype wire

// ### hw/local_bus_address_decoder.sv
// Local bus address decoder with boot memory sequencer
`timescale 1ns/1ps
`default_nettype none
`include "lbd_consts.svh"
module local_bus_address_decoder import lbd_pkg::*; #(
   parameter int TO_SHORT_CYC = `TO_SHORT_US * `CLK_MHZ,
   parameter int TO_MID_CYC = `TO_MID_US * `CLK_MHZ,
   parameter int TO_LONG_CYC = `TO_LONG_US * `CLK_MHZ,
   parameter int ROM_AW = `ROM_AW_DEF
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic req,
   input wire lb_req_t lb,
   input wire logic tgt_ack,
   input wire logic [31:0] tgt_rdata,
   input wire logic boot_select_jumper,
   input wire logic to_en,
   input wire logic [1:0] to_sel,
   input wire logic [31:0] dram_base,
   input wire logic [31:0] dram_mask,
   input wire logic prog_en,
   input wire logic [31:0] prog_base,
   input wire logic [31:0] prog_mask,
   input wire logic [7:0] rom_rdata,
   input wire logic vme_valid,
   input wire logic vme_short,
   input wire logic [31:0] vme_addr,
   input wire logic [5:0] vme_am,
   input wire logic [31:0] vme_slv_start,
   input wire logic [31:0] vme_slv_end,
   input wire logic [63:0] vme_am_accept,
   input wire logic [7:0] global_ctrl_status_block_base,
   output logic ack,
   output logic transfer_error_ack,
   output logic busy,
   output logic [31:0] rdata,
   output logic [NTGT-1:0] sel,
   output rom_bus_t rom,
   output logic vme_hit_local,
   output logic vme_hit_global_ctrl_status_block
);
   localparam logic [23:0] ROM_MASK = 24'((64'h1 << ROM_AW) - 64'h1);

   state_t state, next_state;
   lb_req_t cur, next_cur;
   tgt_t tgt, next_tgt;
   logic [NTGT-1:0] next_sel;
   logic next_ack, next_tea, next_busy;
   logic [31:0] next_rdata, boot_ctrl, next_boot_ctrl, dram_ctrl, next_dram_ctrl;
   rom_bus_t next_rom;
   logic [1:0] idx, next_idx, last, next_last;
   logic phase, next_phase, jmp_m, jmp_s, expired;
   logic next_vme_hit_local, next_vme_hit_global_ctrl_status_block;

   // -----------------------------------------
   // Helpers
   // -----------------------------------------
   function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      in_rng = a >= lo && a <= hi;
   endfunction

   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] l);
      byte_of = w[8*(3-int'(l)) +: 8];
   endfunction

   function automatic logic [3:0] lane_mask(input size_t s, input logic [1:0] a);
      case (s)
         SZ_BYTE: lane_mask = 4'h8 >> a;
         SZ_HALF: lane_mask = a[1] ? 4'h3 : 4'hC;
         default: lane_mask = 4'hF;
      endcase
   endfunction

   function automatic tgt_t decode(input logic [31:0] a, input logic [1:0] tt,
                                   input logic alias_on, input logic dram_hit, input logic prog_hit);
      decode = T_NONE;
      if (tt == `TT_IACK) decode = T_IACK; // [R2]
      else if (in_rng(a, `BOOT_LO, `ALT_HI)) decode = T_BOOT; // [R3]
      else if (alias_on && a <= `ALIAS_HI) decode = T_BOOT; // [R3] [R4]
      else if (a[31:2] == `BOOTCTL_ADR >> 2 || a[31:2] == `DRAMCTL_ADR >> 2) decode = T_REGS;
      else if (in_rng(a, `SRAM_LO, `SRAM_HI)) decode = T_SRAM;
      else if (in_rng(a, `LOCAL_CTRL_STATUS_BLOCK_LO, `LOCAL_CTRL_STATUS_BLOCK_HI)) decode = T_LOCAL_CTRL_STATUS_BLOCK;
      else if (in_rng(a, `GLOBAL_CTRL_STATUS_BLOCK_LO, `GLOBAL_CTRL_STATUS_BLOCK_HI)) decode = T_GLOBAL_CTRL_STATUS_BLOCK;
      else if (in_rng(a, `CTRL_LO, `CTRL_HI)) decode = T_CTRL;
      else if (in_rng(a, `SCC_LO, `SCC_HI)) decode = T_SCC;
      else if (in_rng(a, `LAN_LO, `LAN_HI)) decode = T_LAN;
      else if (in_rng(a, `SCSI_LO, `SCSI_HI)) decode = T_SCSI;
      else if (in_rng(a, `IP_LO, `IP_HI) || in_rng(a, `IPREG_LO, `IPREG_HI)) decode = T_IP;
      else if (in_rng(a, `RTC_LO, `RTC_HI)) decode = T_RTC;
      else if (a >= `A16_LO) decode = T_A16;
      else if (a >= `IO_LO) decode = T_NONE; // [R10]
      else if (dram_hit) decode = T_DRAM; // [R5] [R19]
      else if (prog_hit) decode = T_PROG; // [R9] [R19]
   endfunction

   // -----------------------------------------
   // Jumper synchroniser
   // -----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         jmp_m <= 1'b0;
         jmp_s <= 1'b0;
      end else begin
         jmp_m <= boot_select_jumper;
         jmp_s <= jmp_m;
      end
   end

   lbus_timeout #(
      .SHORT_CYC(TO_SHORT_CYC),
      .MID_CYC(TO_MID_CYC),
      .LONG_CYC(TO_LONG_CYC)
   ) u_timeout (
      .clk(clk),
      .arst_n(arst_n),
      .run(state == ST_TGT && to_en),
      .to_sel(to_sel),
      .expired(expired)
   );

   // -----------------------------------------
   // Access sequencer
   // -----------------------------------------
   always_comb begin
      tgt_t t;
      logic [1:0] lane;
      logic [3:0] m;
      t = T_NONE;
      lane = cur.addr[1:0] + idx;
      m = lane_mask(lb.size, lb.addr[1:0]);
      next_state = state;
      next_cur = cur;
      next_tgt = tgt;
      next_sel = sel;
      next_ack = 1'b0;
      next_tea = 1'b0;
      next_rdata = rdata;
      next_rom = rom;
      next_idx = idx;
      next_last = last;
      next_phase = phase;
      next_boot_ctrl = boot_ctrl;
      next_dram_ctrl = dram_ctrl;
      case (state)
         ST_IDLE: begin
            if (req) begin
               // Tt 0..2 normal map, 3 interrupt acknowledge
               t = decode(lb.addr, lb.access_type_code, !boot_ctrl[`ALIAS_OFF_BIT],
                          dram_ctrl[`DRAM_EN_BIT] && (lb.addr & dram_mask) == dram_base,
                          prog_en && (lb.addr & prog_mask) == prog_base); // [R1] [R5] [R6]
               next_cur = lb;
               next_tgt = t;
               next_idx = 2'h0;
               next_phase = 1'b0;
               next_last = lb.size == SZ_BYTE ? 2'h0 : (lb.size == SZ_HALF ? 2'h1 : 2'h3);
               if (t == T_LOCAL_CTRL_STATUS_BLOCK && lb.write && lb.size != SZ_WORD) begin
                  next_tea = 1'b1; // [R11]
               end else if (t == T_REGS) begin
                  next_ack = 1'b1;
                  next_rdata = lb.addr[3] ? dram_ctrl : boot_ctrl;
                  for (int i = 0; i < 4; i++) begin
                     if (lb.write && m[i] && lb.addr[3]) next_dram_ctrl[8*i +: 8] = lb.wdata[8*i +: 8];
                     if (lb.write && m[i] && !lb.addr[3]) next_boot_ctrl[8*i +: 8] = lb.wdata[8*i +: 8];
                  end
               end else if (t == T_BOOT) begin
                  next_state = ST_ROM;
                  next_rdata = 32'h0;
                  next_rom.cs = 1'b1;
                  next_rom.flash = in_rng(lb.addr, `ALT_LO, `ALT_HI) ? jmp_s : !jmp_s; // [R7]
                  next_rom.rd = !lb.write;
                  next_rom.wr = lb.write;
                  next_rom.addr = lb.addr[23:0] & ROM_MASK; // [R8]
                  next_rom.wdata = byte_of(lb.wdata, lb.addr[1:0]);
               end else begin
                  // Global_ctrl_status_block narrow writes pass like any other access
                  next_state = ST_TGT; // [R12]
                  next_sel = t == T_NONE ? '0 : NTGT'(1) << t; // [R19]
               end
            end
         end
         ST_TGT: begin
            if (tgt != T_NONE && tgt_ack) begin
               next_ack = 1'b1;
               next_rdata = tgt_rdata;
               next_sel = '0;
               next_state = ST_IDLE;
            end else if (expired) begin
               next_tea = 1'b1; // [R9] [R10] [R18]
               next_sel = '0;
               next_state = ST_IDLE;
            end
         end
         ST_ROM: begin
            if (!phase) begin
               next_rom.rd = 1'b0;
               next_rom.wr = 1'b0;
               next_phase = 1'b1;
            end else begin
               // Bytes pack big-endian into the word, lane 0 on top
               if (!cur.write) next_rdata[8*(3-int'(lane)) +: 8] = rom_rdata; // [R8]
               if (idx == last) begin
                  next_ack = 1'b1;
                  next_rom.cs = 1'b0;
                  next_state = ST_IDLE;
               end else begin
                  next_idx = idx + 2'h1;
                  next_phase = 1'b0;
                  next_rom.rd = !cur.write;
                  next_rom.wr = cur.write;
                  next_rom.addr = (rom.addr + 24'h1) & ROM_MASK; // [R8]
                  next_rom.wdata = byte_of(cur.wdata, lane + 2'h1);
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_sel = '0;
            next_rom = '0;
         end
      endcase
      next_busy = next_state != ST_IDLE;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         cur <= '0;
         tgt <= T_NONE;
         sel <= '0;
         ack <= 1'b0;
         transfer_error_ack <= 1'b0;
         busy <= 1'b0;
         rdata <= 32'h0;
         rom <= '0;
         idx <= 2'h0;
         last <= 2'h0;
         phase <= 1'b0;
         boot_ctrl <= `BOOTCTL_RST; // [R3]
         dram_ctrl <= `DRAMCTL_RST;
      end else begin
         state <= next_state;
         cur <= next_cur;
         tgt <= next_tgt;
         sel <= next_sel;
         ack <= next_ack;
         transfer_error_ack <= next_tea;
         busy <= next_busy;
         rdata <= next_rdata;
         rom <= next_rom;
         idx <= next_idx;
         last <= next_last;
         phase <= next_phase;
         boot_ctrl <= next_boot_ctrl;
         dram_ctrl <= next_dram_ctrl;
      end
   end

   // -----------------------------------------
   // Inbound remote decode
   // -----------------------------------------
   always_comb begin
      next_vme_hit_local = vme_valid && !vme_short && vme_addr >= vme_slv_start
                           && vme_addr <= vme_slv_end && vme_am_accept[vme_am]; // [R16]
      next_vme_hit_global_ctrl_status_block = vme_valid && vme_short && vme_addr[15:8] == global_ctrl_status_block_base; // [R17]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vme_hit_local <= 1'b0;
         vme_hit_global_ctrl_status_block <= 1'b0;
      end else begin
         vme_hit_local <= next_vme_hit_local;
         vme_hit_global_ctrl_status_block <= next_vme_hit_global_ctrl_status_block;
      end
   end

   // -----------------------------------------
   // Checks
   // -----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic take;
   assign take = req && state == ST_IDLE;

   local_ctrl_status_block_narrow_a: assert property (take && lb.write && lb.size != SZ_WORD && in_rng(lb.addr, `LOCAL_CTRL_STATUS_BLOCK_LO, `LOCAL_CTRL_STATUS_BLOCK_HI) // [R11]
      |=> transfer_error_ack && !ack && sel == '0) else $error("narrow local CSR write not refused");
   iack_sel_a: assert property (take && lb.access_type_code == `TT_IACK |=> sel[T_IACK]) // [R2]
      else $error("interrupt acknowledge not selected");
   one_sel_a: assert property ($onehot0(sel)) else $error("more than one target select"); // [R19]
   alias_on_a: assert property (take && lb.access_type_code != `TT_IACK && lb.addr <= `ALIAS_HI // [R3]
      && !boot_ctrl[`ALIAS_OFF_BIT] |=> rom.cs && state == ST_ROM) else $error("boot alias missed");
   alias_off_a: assert property (take && lb.addr <= `ALIAS_HI && boot_ctrl[`ALIAS_OFF_BIT] // [R6]
      |=> !rom.cs) else $error("boot alias still decoded");
   dram_gate_a: assert property (!dram_ctrl[`DRAM_EN_BIT] && $stable(dram_ctrl) |=> !sel[T_DRAM]) // [R5]
      else $error("DRAM selected while disabled");
   jumper_route_a: assert property (take && lb.access_type_code != `TT_IACK // [R7]
      && in_rng(lb.addr, `ALT_LO, `ALT_HI) |=> rom.cs && rom.flash == $past(jmp_s))
      else $error("wrong boot device chosen");
   rom_fold_a: assert property (rom.cs |-> (rom.addr & ~ROM_MASK) == 24'h0) // [R8]
      else $error("boot address above device size");
   rom_word_a: assert property (take && lb.access_type_code != `TT_IACK && lb.size == SZ_WORD // [R8]
      && in_rng(lb.addr, `BOOT_LO, `BOOT_HI) |=> rom.rd ##2 rom.rd ##2 rom.rd ##2 rom.rd ##2 ack)
      else $error("word not built from four bytes");
   undecoded_a: assert property (take && lb.access_type_code != `TT_IACK && !prog_en // [R9]
      && in_rng(lb.addr, 32'hFFC00000, 32'hFFDFFFFF) |=> state == ST_TGT && sel == '0)
      else $error("undecoded space selected");
   expiry_tea_a: assert property (state == ST_TGT && tgt == T_NONE && expired |=> transfer_error_ack && !busy) // [R10]
      else $error("timeout without transfer error");
   global_ctrl_status_block_map_a: assert property (vme_valid && vme_short && vme_addr[15:8] == global_ctrl_status_block_base |=> vme_hit_global_ctrl_status_block) // [R17]
      else $error("short I/O global CSR missed");
   vme_am_a: assert property (vme_valid && !vme_am_accept[vme_am] |=> !vme_hit_local) // [R16]
      else $error("refused modifier accepted");

   rom_read_c: cover property (take ##1 state == ST_ROM ##[1:12] ack);
   timeout_c: cover property (state == ST_TGT && tgt == T_NONE ##1 transfer_error_ack);
   target_ack_c: cover property (state == ST_TGT && tgt_ack && tgt != T_NONE ##1 ack);
   reg_write_c: cover property (take && lb.write && lb.addr == `DRAMCTL_ADR);
endmodule
`default_nettype wire

// ### test/lbd_partner.sv
// Target and boot memory responder model
`timescale 1ns/1ps
`default_nettype none
module lbd_partner import lbd_pkg::*; (
   input wire logic clk,
   input wire logic [NTGT-1:0] sel,
   input wire rom_bus_t rom,
   input wire logic [3:0] lat,
   output logic tgt_ack,
   output logic [31:0] tgt_rdata,
   output logic [7:0] rom_rdata
);
   logic [3:0] cnt = 4'h0;
   logic done = 1'b0;
   logic vld = 1'b0;
   logic fl = 1'b0;
   logic [23:0] radr = 24'h0;
   logic [7:0] cyc = 8'h0;
   // Answers a live select once, after a variable wait
   always @(posedge clk) begin
      cyc <= cyc + 8'h1;
      tgt_ack <= 1'b0;
      if (sel == 13'h0) begin
         cnt <= 4'h0;
         done <= 1'b0;
      end else if (!done) begin
         cnt <= cnt + 4'h1;
         if (cnt >= lat) begin
            tgt_ack <= 1'b1;
            done <= 1'b1;
         end
      end
      vld <= rom.cs && rom.rd;
      if (rom.cs && rom.rd) begin
         radr <= rom.addr;
         fl <= rom.flash;
      end
   end
   // Data only valid the cycle after the strobe; a moving pattern otherwise
   assign rom_rdata = vld ? (radr[7:0] ^ radr[19:12] ^ (fl ? 8'hC3 : 8'h3C)) : cyc;
   assign tgt_rdata = tgt_ack ? (32'hC0DE0000 | 32'(sel)) : {4{cyc}};
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the local bus address decoder
`timescale 1ns/1ps
`default_nettype none
`include "lbd_consts.svh"
`define CHK(nm, e, g) begin \
   total_checks++; \
   if ((e) !== (g)) begin \
      num_errors++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
   end \
end
module testbench import lbd_pkg::*;;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic req = 1'b0;
   lb_req_t lb = '0;
   logic jmp = 1'b0, to_en = 1'b1, prog_en = 1'b0, vme_valid = 1'b0, vme_short = 1'b0;
   logic [1:0] to_sel = 2'h0;
   logic [31:0] dram_base = 32'h0, dram_mask = 32'h0, prog_base = 32'h0, prog_mask = 32'h0, vme_addr = 32'h0;
   logic [31:0] vme_start = 32'h01000000, vme_end = 32'h01FFFFFF, w;
   logic [5:0] vme_am = 6'h0;
   logic [63:0] vme_acc = (64'h1 << 13) | (64'h1 << 41);
   logic [7:0] global_ctrl_status_block_base = 8'h5C;
   logic ack, transfer_error_ack, busy, tgt_ack, hit_l, hit_g;
   logic [31:0] rdata, tgt_rdata;
   logic [NTGT-1:0] sel, got_sel;
   rom_bus_t rom;
   logic [7:0] rom_rdata;
   logic [3:0] plat = 4'h0;
   logic [15:0] seed = 16'hCE16;
   int got_n, num_errors = 0, total_checks = 0;
   int tocyc[3] = '{20, 40, 60};
   logic [31:0] uadr[5] = '{32'hFFC00000, 32'hFFDFFFFC, 32'hFFE80000, 32'hFFF00000, 32'hFFF41000};

   always #2.5 clk = ~clk;

   local_bus_address_decoder #(.TO_SHORT_CYC(20), .TO_MID_CYC(40), .TO_LONG_CYC(60)) i_local_bus_address_decoder (
      .clk(clk), .arst_n(arst_n), .req(req), .lb(lb), .tgt_ack(tgt_ack), .tgt_rdata(tgt_rdata),
      .boot_select_jumper(jmp), .to_en(to_en), .to_sel(to_sel), .dram_base(dram_base), .dram_mask(dram_mask),
      .prog_en(prog_en), .prog_base(prog_base), .prog_mask(prog_mask), .rom_rdata(rom_rdata),
      .vme_valid(vme_valid), .vme_short(vme_short), .vme_addr(vme_addr), .vme_am(vme_am),
      .vme_slv_start(vme_start), .vme_slv_end(vme_end), .vme_am_accept(vme_acc), .global_ctrl_status_block_base(global_ctrl_status_block_base),
      .ack(ack), .transfer_error_ack(transfer_error_ack), .busy(busy), .rdata(rdata), .sel(sel), .rom(rom),
      .vme_hit_local(hit_l), .vme_hit_global_ctrl_status_block(hit_g));
   lbd_partner i_lbd_partner (.clk(clk), .sel(sel), .rom(rom), .lat(plat), .tgt_ack(tgt_ack),
      .tgt_rdata(tgt_rdata), .rom_rdata(rom_rdata));

   function automatic logic [31:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      rnd = {seed, ~seed[7:0], seed[15:8]};
   endfunction

   // Expected boot word: four bytes of the folded device address, lane 0 first
   function automatic logic [31:0] romw(input logic [31:0] a, input logic fl);
      logic [31:0] b;
      for (int k = 0; k < 4; k++) begin
         b = (a & 32'h0007FFFF) + 32'(k);
         romw = {romw[23:0], b[7:0] ^ b[19:12] ^ (fl ? 8'hC3 : 8'h3C)};
      end
   endfunction

   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // One access: request held for its cycle only, answer awaited under a bound
   task automatic tx(input string nm, input logic [31:0] a, input logic [1:0] tt, input size_t sz, input logic wr,
         input logic [31:0] wd, input logic [1:0] k, input int lat, input int sx, input bit crd, input logic [31:0] rd);
      logic [31:0] r;
      logic [NTGT-1:0] es;
      r = rnd();
      es = (sx < 0) ? 13'h0 : 13'h1 << sx;
      @(negedge clk);
      req = 1'b1;
      lb = '{a, tt, sz, wr, wd};
      plat = {1'b0, r[2:0]};
      @(negedge clk);
      req = 1'b0;
      lb = ~lb;
      got_sel = 13'h0;
      got_n = 1;
      while (!(ack || transfer_error_ack)) begin
         got_sel = got_sel | sel;
         if (got_n > 400) begin
            $display("BAD %s exp answer got none", nm);
            num_errors++;
            end_sim();
         end
         @(negedge clk);
         got_n++;
      end
      `CHK({nm, " kind"}, k, {transfer_error_ack, ack})
      `CHK({nm, " busy"}, 1'b0, busy)
      if (lat >= 0) `CHK({nm, " cycles"}, lat, got_n)
      `CHK({nm, " select"}, es, got_sel)
      if (crd) `CHK({nm, " data"}, rd, rdata)
   endtask

   task automatic vm(input logic sh, input logic [31:0] a, input logic [5:0] am, input logic el, input logic eg);
      @(negedge clk);
      vme_valid = 1'b1;
      vme_short = sh;
      vme_addr = a;
      vme_am = am;
      @(negedge clk);
      vme_valid = 1'b0;
      `CHK("remote window hit", el, hit_l)
      `CHK("remote csr hit", eg, hit_g)
   endtask

   // Two selects at once would put two targets on the bus
   always @(negedge clk) begin
      if (arst_n && !$onehot0(sel)) begin
         num_errors++;
         $display("BAD select onehot exp 1 got %0h", sel);
      end
   end

   // ----------
   // Stimulus
   // ----------
   initial begin
      logic [31:0] ra;
      repeat (3) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      for (int r = 0; r < 2; r++) begin
         ra = r ? `DRAMCTL_ADR : `BOOTCTL_ADR;
         w = rnd();
         tx("reg reset", ra, 2'h0, SZ_WORD, 1'b0, 32'h0, 2'h1, 1, -1, 1, 32'h0);
         tx("reg wr", ra, 2'h0, SZ_WORD, 1'b1, w, 2'h1, 1, -1, 0, 32'h0);
         tx("reg rd", ra, 2'h1, SZ_WORD, 1'b0, 32'h0, 2'h1, 1, -1, 1, w);
         tx("reg clr", ra, 2'h2, SZ_WORD, 1'b1, 32'h0, 2'h1, 1, -1, 0, 32'h0);
      end
      $display("test registers done");
      jmp = 1'b1;
      repeat (4) @(negedge clk);
      for (int s = 0; s < 3; s++)
         // One request edge, then two edges per byte; answer registered on the edge that takes the last byte
         tx("boot size", 32'hFF800100, 2'h0, size_t'(s), 1'b0, 32'h0, 2'h1, (2 << s) + 1, -1, 0, 32'h0);
      tx("alias", 32'h00000104, 2'h2, SZ_WORD, 1'b0, 32'h0, 2'h1, 9, -1, 1, romw(32'h104, 1'b0));
      tx("boot top", 32'hFF9FFF04, 2'h1, SZ_WORD, 1'b0, 32'h0, 2'h1, 9, -1, 1, romw(32'hFF9FFF04, 1'b0));
      for (int j = 0; j < 2; j++) begin
         jmp = j[0];
         repeat (4) @(negedge clk);
         tx("alt", 32'hFFA00208, 2'h0, SZ_WORD, 1'b0, 32'h0, 2'h1, 9, -1, 1, romw(32'hFFA00208, j[0]));
         tx("boot", 32'hFF800208, 2'h0, SZ_WORD, 1'b0, 32'h0, 2'h1, 9, -1, 1, romw(32'hFF800208, !j[0]));
      end
      $display("test boot memory done");
      // Alias goes off before DRAM is enabled, as start-up code must do
      tx("alias off", `BOOTCTL_ADR, 2'h0, SZ_WORD, 1'b1, 32'h1 << `ALIAS_OFF_BIT, 2'h1, 1, -1, 0, 32'h0);
      tx("low gone", 32'h10, 2'h0, SZ_WORD, 1'b0, 32'h0, 2'h2, tocyc[0] + 2, -1, 0, 32'h0);
      dram_mask = 32'hFFC00000;
      tx("dram on", `DRAMCTL_ADR, 2'h0, SZ_WORD, 1'b1, 32'h1 << `DRAM_EN_BIT, 2'h1, 1, -1, 0, 32'h0);
      tx("dram", 32'h10, 2'h0, SZ_WORD, 1'b0, 32'h0, 2'h1, -1, 0, 1, 32'hC0DE0001);
      $display("test alias and dram done");
      for (int t = 0; t < 3; t++) begin
         to_sel = 2'(t);
         foreach (uadr[u])
            tx("undecoded", uadr[u], 2'h0, SZ_WORD, 1'b0, 32'h0, 2'h2, tocyc[t] + 2, -1, 0, 32'h0);
      end
      to_sel = 2'h0;
      $display("test timeout done");
      for (int s = 0; s < 3; s++) begin
         tx("local_ctrl_status_block wr", 32'hFFF40010, 2'h0, size_t'(s), 1'b1, w, s == 2 ? 2'h1 : 2'h2, s == 2 ? -1 : 1,
            s == 2 ? 2 : -1, 0, 32'h0);
         tx("global_ctrl_status_block wr", 32'hFFF40110, 2'h0, size_t'(s), 1'b1, w, 2'h1, -1, 3, 0, 32'h0);
         tx("local_ctrl_status_block rd", 32'hFFF40013, 2'h0, size_t'(s), 1'b0, 32'h0, 2'h1, -1, 2, 0, 32'h0);
         tx("global_ctrl_status_block rd", 32'hFFF40113, 2'h0, size_t'(s), 1'b0, 32'h0, 2'h1, -1, 3, 0, 32'h0);
      end
      $display("test csr widths done");
      // DRAM window over everything: fixed regions must still win
      dram_mask = 32'h0;
      prog_en = 1'b1;
      prog_base = 32'hFFC00000;
      prog_mask = 32'hFFE00000;
      for (int t = 0; t < 4; t++)
         tx("type", 32'hFFE00100, 2'(t), SZ_WORD, 1'b0, 32'h0, 2'h1, -1, t == 3 ? 12 : 1, 1,
            t == 3 ? 32'hC0DE1000 : 32'hC0DE0002);
      tx("serial", 32'hFFF45003, 2'h0, SZ_BYTE, 1'b1, w, 2'h1, -1, 5, 0, 32'h0);
      for (int h = 0; h < 2; h++)
         tx("port cmd", 32'hFFF46000, 2'h0, SZ_HALF, 1'b1, h ? w : w >> 16, 2'h1, -1, 6, 0, 32'h0);
      tx("prog lose", 32'hFFC00000, 2'h0, SZ_WORD, 1'b0, 32'h0, 2'h1, -1, 0, 1, 32'hC0DE0001);
      dram_mask = 32'hFFC00000;
      tx("prog", 32'hFFC00000, 2'h0, SZ_WORD, 1'b0, 32'h0, 2'h1, -1, 11, 1, 32'hC0DE0800);
      $display("test priority done");
      vm(1'b0, 32'h01000040, 6'h0D, 1'b1, 1'b0);
      vm(1'b0, 32'h02000000, 6'h0D, 1'b0, 1'b0);
      vm(1'b0, 32'h01000040, 6'h09, 1'b0, 1'b0);
      vm(1'b1, 32'h00005C10, 6'h29, 1'b0, 1'b1);
      vm(1'b1, 32'h00005D10, 6'h29, 1'b0, 1'b0);
      $display("test remote decode done");
      end_sim();
   end
endmodule
`default_nettype wire
